// file: design/capability_map_pkg.sv
// Constants for the host adapter register aperture: offsets, fields, defaults.
package capability_map_pkg;

    // Aperture layout, byte offsets relative to the memory base
    localparam logic [9:0]  GLOBAL_END       = 10'h023;
    localparam logic [9:0]  VENDOR_START     = 10'h0A0;
    localparam logic [9:0]  PORT_AREA_START  = 10'h100;
    localparam logic [9:0]  PORT_AREA_END    = 10'h2FF;
    localparam int          PORT_BLOCK_SHIFT = 7;       // 128-byte port blocks
    localparam int          BASE_LSB         = 10;      // base aligned to 1 KiB
    localparam int          NUM_PORTS        = 4;

    // Global register offsets
    localparam logic [9:0]  OFS_FEATURE      = 10'h000;
    localparam logic [9:0]  OFS_GCTRL        = 10'h004;
    localparam logic [9:0]  OFS_IRQ_STATUS   = 10'h008;
    localparam logic [9:0]  OFS_PRESENCE     = 10'h00C;
    localparam logic [9:0]  OFS_REVISION     = 10'h010;
    localparam logic [9:0]  OFS_CCC_CTRL     = 10'h014;
    localparam logic [9:0]  OFS_COALESCE_PORT_MASK    = 10'h018;
    localparam logic [9:0]  OFS_ENCLOSURE_MSG_LOCATION       = 10'h01C;
    localparam logic [9:0]  OFS_EM_CTRL      = 10'h020;

    // Offsets inside one port block for the upper pointer halves
    localparam logic [6:0]  OFS_LIST_UPPER   = 7'h04;
    localparam logic [6:0]  OFS_FIS_UPPER    = 7'h0C;

    // Feature word fields
    localparam logic [4:0]  PORT_COUNT_FIELD = 5'h03;   // four ports
    localparam logic        EXTERNAL_PORT    = 1'h0;
    localparam logic        ENCLOSURE_FLAG   = 1'h0;
    localparam logic        COALESCING_FLAG  = 1'h1;
    localparam logic [4:0]  SLOT_COUNT_FIELD = 5'h1F;   // thirty-two slots
    localparam logic        PARTIAL_CAPABLE  = 1'h1;
    localparam logic        SLUMBER_CAPABLE  = 1'h1;
    localparam logic        MULTI_BLOCK_PIO  = 1'h1;
    localparam logic        FRAME_SWITCHING  = 1'h0;
    localparam logic        MULTIPLIER_FLAG  = 1'h1;
    localparam logic        NATIVE_ONLY      = 1'h0;
    localparam logic        NONZERO_OFFSET   = 1'h0;
    localparam logic [3:0]  MAX_LINK_SPEED   = 4'h2;
    localparam logic        LIST_OVERRIDE    = 1'h1;
    localparam logic        ACTIVITY_LED     = 1'h1;
    localparam logic        AUTO_LINK_POWER  = 1'h1;
    localparam logic        STAGGERED_RESET  = 1'h0;
    localparam logic        PRESENCE_RESET   = 1'h1;
    localparam logic        NOTIFY_REGISTER  = 1'h1;
    localparam logic        NATIVE_QUEUING   = 1'h1;
    localparam logic        WIDE_ADDRESSING  = 1'h1;
    localparam int          STAGGERED_BIT    = 27;
    localparam int          PRESENCE_BIT     = 28;

    // Other global register contents
    localparam logic [31:0] PRESENCE_VALUE   = 32'h0000000F;
    localparam logic [31:0] REVISION_VALUE   = 32'h00010100;
    localparam int          GCTRL_RESET_BIT  = 0;
    localparam int          GCTRL_IRQ_BIT    = 1;
    localparam int          GCTRL_NATIVE_BIT = 31;
    localparam int          CCC_EN_BIT       = 0;
    localparam logic [4:0]  CCC_INT_VALUE    = 5'h1F;
    localparam logic [7:0]  CCC_CC_RESET     = 8'h01;
    localparam logic [15:0] CCC_TV_RESET     = 16'h0001;

endpackage : capability_map_pkg

// file: design/upper_pointer_reg.sv
// Upper 32 address bits of one port pointer, writable only with wide addressing.
`timescale 1ns/100ps
`default_nettype none

module upper_pointer_reg
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Control
    input  wire logic        wide_enable,
    input  wire logic        write_en,
    input  wire logic [31:0] write_data,
    // Stored value
    output logic      [31:0] value
);

    logic [31:0] upper_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            upper_q <= 32'h00000000;
        else if (write_en && wide_enable)
            upper_q <= write_data;
    end

    assign value = wide_enable ? upper_q : 32'h00000000;

endmodule : upper_pointer_reg

`default_nettype wire

// file: design/sata_host_capability_map.sv
// Memory-mapped global register aperture of the serial storage host adapter.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Decode aperture from base: globals, vendor area, four 128-byte port blocks.
// - Global registers sit at 4-byte steps in the fixed documented order.
// - Feature bits 4:0 hold zero-based port count, default three.
// - Feature bits 12:8 hold zero-based slot count, thirty-two per port.
// - Feature bits 23:20 hold maximum link speed, default code two.
// - Bit 31 set makes upper pointer halves writable; clear means zero.
// - Enclosure flag bit 6 is zero, so enclosure registers are absent.
// - Coalescing flag bit 7 is one, so coalescing registers exist.
// - Bits 13 and 14 advertise partial and slumber power states.
// - Bit 15 set advertises multi-block programmed transfers.
// - Bit 17 set for command-switched multiplier, bit 16 clear.
// - Bit 18 clear: legacy task-file interface also offered.
// - Bit 19 reads zero, non-zero offsets not supported.
// - Bit 24 set advertises command-list override.
// - Bit 25 set; one activity output reflects any drive activity.
// - Bit 26 set; device requests low power for an idle port while the control native bit is set.
// - Bits 27 and 28 default zero and one; firmware may load them.
// - Bit 29 set advertises per-port notification register.
// - Bit 30 set advertises native command queuing.
module sata_host_capability_map
    import capability_map_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Memory base register load
    input  wire logic                 base_wr,
    input  wire logic [31:0]          base_wdata,
    // Memory aperture access
    input  wire logic [31:0]          mem_addr,
    input  wire logic                 mem_rd,
    input  wire logic                 mem_wr,
    input  wire logic [31:0]          mem_wdata,
    output logic      [31:0]          mem_rdata_q,
    output logic                      mem_ack_q,
    // Firmware strap load for feature bits 27 and 28
    input  wire logic                 fw_load,
    input  wire logic                 fw_staggered,
    input  wire logic                 fw_presence,
    // Port status from the link side
    input  wire logic [NUM_PORTS-1:0] port_event,
    input  wire logic [NUM_PORTS-1:0] drive_active,
    input  wire logic [NUM_PORTS-1:0] port_idle,
    // Control outputs
    output logic      [31:0]          memory_base_q,
    output logic                      hba_reset_q,
    output logic                      irq_enable_q,
    output logic                      native_enable_q,
    output logic                      coalesce_enable_q,
    output logic      [NUM_PORTS-1:0] coalesce_ports_q,
    output logic                      activity_led_q,
    output logic      [NUM_PORTS-1:0] link_pm_req_q
);

    logic        staggered_q;
    logic        presence_q;
    logic [31:0] feature_word;
    logic [31:0] irq_status_q;
    logic [7:0]  ccc_count_q;
    logic [15:0] ccc_timeout_q;
    logic [31:0] ccc_ctrl_word;
    logic [31:0] gctrl_word;
    logic        hit;
    logic        in_global;
    logic [9:0]  offset;
    logic        in_ports;
    logic [1:0]  port_sel;
    logic [6:0]  port_ofs;
    logic [31:0] rdata_d;
    logic [31:0] list_upper [NUM_PORTS];
    logic [31:0] fis_upper  [NUM_PORTS];

    assign hit      = (mem_addr[31:BASE_LSB] == memory_base_q[31:BASE_LSB]);
    assign offset   = mem_addr[BASE_LSB-1:0];
    assign port_ofs = offset[PORT_BLOCK_SHIFT-1:0];

    // region decode in address order: globals, gap, vendor area, port blocks.
    // The gap, the vendor area and the top of the aperture hold no registers here.
    always_comb
    begin
        in_global = 1'b0;
        in_ports  = 1'b0;
        port_sel  = 2'b00;
        if (offset <= GLOBAL_END)
            in_global = 1'b1;
        else if (offset < VENDOR_START)
            in_global = 1'b0;               // Reserved gap after the globals
        else if (offset < PORT_AREA_START)
            in_global = 1'b0;               // Vendor area, nothing behind it
        else if (offset <= PORT_AREA_END)
        begin
            in_ports = 1'b1;
            // 128-byte blocks, so the block number sits just above the in-block offset
            port_sel = 2'((offset - PORT_AREA_START) >> PORT_BLOCK_SHIFT);
        end
        else
            in_ports = 1'b0;                // Above port three, reserved
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            memory_base_q <= 32'h00000000;
        else if (base_wr)
            memory_base_q <= {base_wdata[31:BASE_LSB], {BASE_LSB{1'b0}}};
    end

    // firmware loads spin-up and presence bits
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            staggered_q <= STAGGERED_RESET;
            presence_q  <= PRESENCE_RESET;
        end
        else if (fw_load)
        begin
            staggered_q <= fw_staggered;
            presence_q  <= fw_presence;
        end
    end

    assign feature_word = {WIDE_ADDRESSING, NATIVE_QUEUING, NOTIFY_REGISTER,
                           presence_q, staggered_q, AUTO_LINK_POWER, ACTIVITY_LED,
                           LIST_OVERRIDE, MAX_LINK_SPEED, NONZERO_OFFSET,
                           NATIVE_ONLY, MULTIPLIER_FLAG, FRAME_SWITCHING,
                           MULTI_BLOCK_PIO, SLUMBER_CAPABLE, PARTIAL_CAPABLE,
                           SLOT_COUNT_FIELD, COALESCING_FLAG, ENCLOSURE_FLAG,
                           EXTERNAL_PORT, PORT_COUNT_FIELD};

    // Global control: adapter reset bit clears itself one cycle after it is set
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hba_reset_q     <= 1'b0;
            irq_enable_q    <= 1'b0;
            native_enable_q <= 1'b0;
        end
        else if (mem_wr && hit && offset == OFS_GCTRL)
        begin
            // writing zero to the reset bit has no effect
            hba_reset_q     <= mem_wdata[GCTRL_RESET_BIT];
            irq_enable_q    <= mem_wdata[GCTRL_IRQ_BIT];
            native_enable_q <= mem_wdata[GCTRL_NATIVE_BIT];
        end
        else
            hba_reset_q <= 1'b0;
    end

    assign gctrl_word = {native_enable_q, 28'h0000000, 1'b0, irq_enable_q, hba_reset_q};

    // Port event status, write one to clear; a new event wins over the clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_status_q <= 32'h00000000;
        else if (mem_wr && hit && offset == OFS_IRQ_STATUS)
            irq_status_q <= (irq_status_q & ~mem_wdata)
                            | {{(32-NUM_PORTS){1'b0}}, port_event};
        else
            irq_status_q <= irq_status_q | {{(32-NUM_PORTS){1'b0}}, port_event};
    end

    // coalescing registers present because the flag is set
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            coalesce_enable_q <= 1'b0;
            ccc_count_q       <= CCC_CC_RESET;
            ccc_timeout_q     <= CCC_TV_RESET;
            coalesce_ports_q  <= '0;
        end
        else if (COALESCING_FLAG && mem_wr && hit)
        begin
            if (offset == OFS_CCC_CTRL)
            begin
                coalesce_enable_q <= mem_wdata[CCC_EN_BIT];
                ccc_count_q       <= mem_wdata[15:8];
                ccc_timeout_q     <= mem_wdata[31:16];
            end
            else if (offset == OFS_COALESCE_PORT_MASK)
            begin
                // Only implemented ports may join coalescing
                coalesce_ports_q <= mem_wdata[NUM_PORTS-1:0]
                                    & PRESENCE_VALUE[NUM_PORTS-1:0];
            end
        end
    end

    assign ccc_ctrl_word = {ccc_timeout_q, ccc_count_q, CCC_INT_VALUE, 2'b00,
                            coalesce_enable_q};

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++)
        begin : g_port
            upper_pointer_reg u_list_upper
            (
                .clk        (clk),
                .rst_n      (rst_n),
                .wide_enable(WIDE_ADDRESSING),
                .write_en   (mem_wr && hit && in_ports && port_sel == 2'(p)
                             && port_ofs == OFS_LIST_UPPER),
                .write_data (mem_wdata),
                .value      (list_upper[p])
            );
            upper_pointer_reg u_fis_upper
            (
                .clk        (clk),
                .rst_n      (rst_n),
                .wide_enable(WIDE_ADDRESSING),
                .write_en   (mem_wr && hit && in_ports && port_sel == 2'(p)
                             && port_ofs == OFS_FIS_UPPER),
                .write_data (mem_wdata),
                .value      (fis_upper[p])
            );
        end
    endgenerate

    // global read decode in fixed order
    always_comb
    begin
        rdata_d = 32'h00000000;
        if (!hit)
            rdata_d = 32'h00000000;
        else if (!in_global && !in_ports)
            rdata_d = 32'h00000000;
        else if (offset == OFS_FEATURE)
            rdata_d = feature_word;
        else if (offset == OFS_GCTRL)
            rdata_d = gctrl_word;
        else if (offset == OFS_IRQ_STATUS)
            rdata_d = irq_status_q;
        else if (offset == OFS_PRESENCE)
            rdata_d = PRESENCE_VALUE;
        else if (offset == OFS_REVISION)
            rdata_d = REVISION_VALUE;
        else if (offset == OFS_CCC_CTRL && COALESCING_FLAG)
            rdata_d = ccc_ctrl_word;
        else if (offset == OFS_COALESCE_PORT_MASK && COALESCING_FLAG)
            rdata_d = {{(32-NUM_PORTS){1'b0}}, coalesce_ports_q};
        // enclosure registers not implemented while flag clear
        else if ((offset == OFS_ENCLOSURE_MSG_LOCATION || offset == OFS_EM_CTRL) && !ENCLOSURE_FLAG)
            rdata_d = 32'h00000000;
        else if (in_ports && port_ofs == OFS_LIST_UPPER)
            rdata_d = list_upper[port_sel];
        else if (in_ports && port_ofs == OFS_FIS_UPPER)
            rdata_d = fis_upper[port_sel];
        // reserved, vendor and unimplemented offsets read zero
        else
            rdata_d = 32'h00000000;
    end

    // Read data registered; acknowledge one cycle after any access in the aperture
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_rdata_q <= 32'h00000000;
            mem_ack_q   <= 1'b0;
        end
        else
        begin
            mem_rdata_q <= mem_rd ? rdata_d : 32'h00000000;
            mem_ack_q   <= (mem_rd || mem_wr) && hit;
        end
    end

    // one activity pin for any drive
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            activity_led_q <= 1'b0;
        else
            activity_led_q <= ACTIVITY_LED && (|drive_active);
    end

    // low-power request for each idle port while native mode is enabled
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            link_pm_req_q <= '0;
        else
            link_pm_req_q <= (AUTO_LINK_POWER && native_enable_q)
                             ? (port_idle & PRESENCE_VALUE[NUM_PORTS-1:0]) : '0;
    end

endmodule : sata_host_capability_map

`default_nettype wire

// file: tb/capability_map_chk.sv
// Port-level checker for the host adapter register aperture.
`timescale 1ns/100ps
`default_nettype none

module capability_map_chk
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Base load and aperture access
    input wire logic        base_wr,
    input wire logic [31:0] base_wdata,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata_q,
    input wire logic        mem_ack_q,
    // Link side and control outputs
    input wire logic [3:0]  drive_active,
    input wire logic [3:0]  port_idle,
    input wire logic [31:0] memory_base_q,
    input wire logic        hba_reset_q,
    input wire logic        native_enable_q,
    input wire logic [3:0]  coalesce_ports_q,
    input wire logic        activity_led_q,
    input wire logic [3:0]  link_pm_req_q
);
    logic hit;
    logic req;

    // Aperture hit; base and access are never changed in the same cycle
    assign hit = (mem_addr[31:10] == memory_base_q[31:10]);
    assign req = (mem_rd | mem_wr) & hit;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    base_align_a: assert property (base_wr |=> memory_base_q == {$past(base_wdata[31:10]), 10'h000})
        else $error("base register not loaded aligned");
    hit_ack_a: assert property (req |=> mem_ack_q)
        else $error("aperture hit not acknowledged");
    miss_no_ack_a: assert property (!req |=> !mem_ack_q)
        else $error("acknowledge without a hit");
    idle_rdata_a: assert property (!mem_rd |=> mem_rdata_q == 32'h00000000)
        else $error("read data not zero outside reads");
    feature_value_a: assert property (mem_rd && hit && mem_addr[9:0] == 10'h000
        |=> (mem_rdata_q & 32'hE7FFFFFF) == 32'hE722FF83)
        else $error("feature word fixed bits wrong");
    reserved_zero_a: assert property (mem_rd && hit
        && (mem_addr[9:8] == 2'b11 || mem_addr[9:0] inside {10'h01C, 10'h020})
        |=> mem_rdata_q == 32'h00000000)
        else $error("reserved offset read not zero");
    coalesce_ports_a: assert property (mem_wr && hit && mem_addr[9:0] == 10'h018
        |=> coalesce_ports_q == $past(mem_wdata[3:0]))
        else $error("coalescing port mask not written");
    led_follow_a: assert property (|drive_active |=> activity_led_q)
        else $error("activity output missed drive activity");
    led_quiet_a: assert property (!(|drive_active) |=> !activity_led_q)
        else $error("activity output without activity");
    idle_request_a: assert property (##1 link_pm_req_q
        == ($past(native_enable_q) ? $past(port_idle) : 4'h0))
        else $error("link power request not following idle ports");
    reset_pulse_a: assert property (hba_reset_q |=> !hba_reset_q)
        else $error("adapter reset bit did not self clear");
endmodule : capability_map_chk

bind sata_host_capability_map capability_map_chk chk_u (.clk(clk), .rst_n(rst_n),
    .base_wr(base_wr), .base_wdata(base_wdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata_q(mem_rdata_q), .mem_ack_q(mem_ack_q),
    .drive_active(drive_active), .port_idle(port_idle), .memory_base_q(memory_base_q),
    .hba_reset_q(hba_reset_q), .native_enable_q(native_enable_q),
    .coalesce_ports_q(coalesce_ports_q), .activity_led_q(activity_led_q),
    .link_pm_req_q(link_pm_req_q));

`default_nettype wire

// file: tb/tb_sata_host_capability_map.sv
// Self-checking bench for the host adapter register aperture.
`timescale 1ns/100ps
`default_nettype none

module tb_sata_host_capability_map;
    import capability_map_pkg::*;

    localparam logic [31:0] BASE = 32'hFEBFF000;
    localparam logic [31:0] FEAT = 32'hF722FF83;

    logic        clk, rst_n, base_wr, mem_rd, mem_wr, fw_load, fw_staggered, fw_presence;
    logic [31:0] base_wdata, mem_addr, mem_wdata, mem_rdata_q, memory_base_q;
    logic [3:0]  port_event, drive_active, port_idle, coalesce_ports_q, link_pm_req_q;
    logic        mem_ack_q, hba_reset_q, irq_enable_q, native_enable_q;
    logic        coalesce_enable_q, activity_led_q;
    int          errors, check_count;
    logic [9:0]  ofs_list [7] = '{10'h01C, 10'h020, 10'h024, 10'h0A0, 10'h0FC, 10'h300, 10'h3FC};

    sata_host_capability_map dut_u (.clk(clk), .rst_n(rst_n), .base_wr(base_wr),
        .base_wdata(base_wdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata_q(mem_rdata_q), .mem_ack_q(mem_ack_q),
        .fw_load(fw_load), .fw_staggered(fw_staggered), .fw_presence(fw_presence),
        .port_event(port_event), .drive_active(drive_active), .port_idle(port_idle),
        .memory_base_q(memory_base_q), .hba_reset_q(hba_reset_q), .irq_enable_q(irq_enable_q),
        .native_enable_q(native_enable_q), .coalesce_enable_q(coalesce_enable_q),
        .coalesce_ports_q(coalesce_ports_q), .activity_led_q(activity_led_q),
        .link_pm_req_q(link_pm_req_q));

    // 50 MHz clock
    always #10 clk = ~clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("Error at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // One request held for one edge; answer sampled just after that edge
    task automatic access(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                          input logic [31:0] exp, input logic ack);
        @(posedge clk);
        #1;
        mem_addr = addr;
        mem_wdata = wdata;
        mem_rd = !wr;
        mem_wr = wr;
        @(posedge clk);
        #1;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        check({31'h0, mem_ack_q}, {31'h0, ack});
        if (!wr)
            check(mem_rdata_q, exp);
    endtask : access

    task automatic rd(input logic [9:0] ofs, input logic [31:0] exp);
        access(1'b0, BASE + {22'h0, ofs}, 32'h00000000, exp, 1'b1);
    endtask : rd

    task automatic wr(input logic [9:0] ofs, input logic [31:0] data);
        access(1'b1, BASE + {22'h0, ofs}, data, 32'h00000000, 1'b1);
    endtask : wr

    // Cuts a hang short; the whole sequence needs well under 500 cycles
    initial
    begin
        #100000;
        errors = errors + 1;
        tally_and_finish();
    end

    initial
    begin
        {clk, rst_n, base_wr, mem_rd, mem_wr, fw_load, fw_staggered, fw_presence} = 8'h00;
        {base_wdata, mem_addr, mem_wdata} = 96'h0;
        {port_event, drive_active, port_idle} = 12'h000;
        errors = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        @(posedge clk);
        #1;
        base_wr = 1'b1;
        base_wdata = BASE | 32'h00000155;
        @(posedge clk);
        #1;
        base_wr = 1'b0;
        check(memory_base_q, BASE);
        rd(10'h000, FEAT);
        wr(10'h000, 32'h00000000);
        rd(10'h000, FEAT);
        // Firmware straps flip both loadable bits
        fw_staggered = 1'b1;
        fw_load = 1'b1;
        @(posedge clk);
        #1;
        fw_load = 1'b0;
        rd(10'h000, 32'hEF22FF83);
        rd(10'h00C, 32'h0000000F);
        rd(10'h010, 32'h00010100);
        // Port event latched, then cleared by writing one
        port_event = 4'h4;
        @(posedge clk);
        #1;
        port_event = 4'h0;
        rd(10'h008, 32'h00000004);
        wr(10'h008, 32'h00000004);
        rd(10'h008, 32'h00000000);
        rd(10'h014, 32'h000101F8);
        wr(10'h018, 32'hFFFFFFFF);
        rd(10'h018, 32'h0000000F);
        wr(10'h014, 32'h00000001);
        check({31'h0, coalesce_enable_q}, 32'h1);
        // Reserved, vendor and out-of-block offsets ignore writes
        foreach (ofs_list[i])
        begin
            wr(ofs_list[i], 32'hFFFFFFFF);
            rd(ofs_list[i], 32'h00000000);
        end
        // Upper pointer halves of each 128-byte port block
        for (int n = 0; n < 4; n++)
        begin
            wr(10'h104 + 10'(n * 128), 32'hA5000000 + 32'(n));
            wr(10'h10C + 10'(n * 128), 32'h5A000000 + 32'(n));
            rd(10'h104 + 10'(n * 128), 32'hA5000000 + 32'(n));
            rd(10'h10C + 10'(n * 128), 32'h5A000000 + 32'(n));
        end
        access(1'b0, BASE + 32'h00000400, 32'h0, 32'h00000000, 1'b0);
        access(1'b1, BASE - 32'h00000004, 32'h0, 32'h00000000, 1'b0);
        wr(10'h004, 32'h80000002);
        rd(10'h004, 32'h80000002);
        check({30'h0, native_enable_q, irq_enable_q}, 32'h3);
        port_idle = 4'hA;
        drive_active = 4'h2;
        repeat (2) @(posedge clk);
        #1;
        check({28'h0, link_pm_req_q}, 32'hA);
        check({31'h0, activity_led_q}, 32'h1);
        drive_active = 4'h0;
        repeat (2) @(posedge clk);
        #1;
        check({31'h0, activity_led_q}, 32'h0);
        wr(10'h004, 32'h80000003);
        check({31'h0, hba_reset_q}, 32'h1);
        @(posedge clk);
        #1;
        check({31'h0, hba_reset_q}, 32'h0);
        // Clearing the native enable withdraws every link power request
        wr(10'h004, 32'h00000000);
        @(posedge clk);
        #1;
        check({28'h0, link_pm_req_q}, 32'h0);
        // Let the checker see the last consequents before the run ends
        repeat (2) @(posedge clk);
        tally_and_finish();
    end
endmodule : tb_sata_host_capability_map

`default_nettype wire
